/* hw/chg_sup_pkg.sv */
/*
 * constants for the charger supervisory block: register map, field codes,
 * timing figures and state encodings.
 * assumes a 40 MHz system clock and an Avalon-MM register master.
 */
// Overview of operation
// - boost out of thermistor window: suspend boost, source field 000, report cold/hot.
// - thermistor back in window: resume boost, clear thermistor fault to 000.
// - safety timer expiry stops charging, charge fault 11, interrupt pulse.
// - default limits: 2 hours below low-battery threshold, 6 hours above it.
// - timer enable bit cleared disables the safety timer completely.
// - long-select bit cleared shortens the six hour limit to 4 hours.
// - count at half rate under input limits, cool current cut or thermal regulation.
// - slow-down enable bit cleared forces full rate counting always.
// - fault suspending charge holds timer; counting resumes from held value.
// - restart, enable pin toggle or config bit toggle zero the timer.
// - three-bit minimum system voltage field, reset default meaning 3.5V.
// - system regulation flag high while rail held at minimum setting.
// - input current and input voltage limit flags follow limiting state.
// - switch disable opens switch at once, or after 8 seconds with delay bit.
// - valid input or wake pin low at least 1s re-enables the switch.
// - with input, exit ship by clearing disable, register reset, or wake pulse.
// - no input, switch allowed, wake low 16s: switch off 250ms then on.
// - long-press reset ignored while long-press reset enable bit is 0.
// - good input and detection done: power good flag high, pin low.
// - input good needs window, not sleep, not poor source, detection done.
// - each interrupt is an active-low pulse of 256us.
// - charge fault codes: 00 none, 01 overvoltage, 10 thermal shutdown.
package chg_sup_pkg;
    localparam int CLK_HZ = 40000000;
    // timebase tick of 1 ms used by every long counter
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TMR_W = 25;
    localparam int SAFE_SHORT_H = 2;
    localparam int SAFE_LONG_H = 6;
    localparam int SAFE_MID_H = 4;
    localparam int MS_PER_H = 3600000;
    localparam int INT_PULSE_US = 256;
    localparam int INT_PULSE_CYC = INT_PULSE_US * (CLK_HZ / 1000000);
    localparam int SHIP_DLY_MS = 8000;
    localparam int DEGLITCH_MS = 1000;
    localparam int LONG_PRESS_MS = 16000;
    localparam int SW_OFF_MS = 250;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_TMR = 4'h8;
    // control register bit positions
    localparam int C_TMR_EN = 0;
    localparam int C_LONG_SEL = 1;
    localparam int C_SLOW_EN = 2;
    localparam int C_CHG_CFG = 3;
    localparam int C_SW_DIS = 4;
    localparam int C_SW_DLY = 5;
    localparam int C_LP_EN = 6;
    localparam int C_REG_RST = 7;
    localparam int C_SYSMIN_LO = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_054f;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;
    localparam logic [2:0] SYSMIN_RST = 3'h5;
    localparam logic [1:0] CF_NONE = 2'h0;
    localparam logic [1:0] CF_OVP = 2'h1;
    localparam logic [1:0] CF_TSHUT = 2'h2;
    localparam logic [1:0] CF_TIMER = 2'h3;
    localparam logic [2:0] NTC_NORMAL = 3'h0;
    localparam logic [2:0] NTC_COLD = 3'h5;
    localparam logic [2:0] NTC_HOT = 3'h6;
    localparam logic [2:0] SRC_NONE = 3'h0;
    typedef enum logic [3:0] {
        SW_ON = 4'b0001,
        SW_WAIT = 4'b0010,
        SW_OFF = 4'b0100,
        SW_RST = 4'b1000
    } sw_state_t;
endpackage

/* hw/chg_press_timer.sv */
/*
 * measures how long the wake pin has been held low, in timebase ticks.
 * assumes the pin level is already synchronised to the clock.
 */
module chg_press_timer #(
    parameter int CNT_W = 15
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic pin_low_i,
    output logic [CNT_W-1:0] low_ms_o
);
    // restart on release so glitches never add up; saturate at all ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_ms_o <= '0;
        end else if (ce_i) begin
            if (!pin_low_i) begin
                low_ms_o <= '0;
            end else if (tick_i && low_ms_o != {CNT_W{1'b1}}) begin
                low_ms_o <= low_ms_o + 1'b1;
            end
        end
    end
endmodule

/* hw/chg_supervisor.sv */
/*
 * charger supervisor: safety timer, boost thermistor suspend, status flags,
 * battery switch / ship mode control, wake pin timing and power good.
 * assumes analog comparators arrive as asynchronous levels, and a single
 * Avalon-MM master on the register port with waitrequest.
 */
module chg_supervisor #(
    parameter int TICK_CYC = chg_sup_pkg::TICK_CYC,
    parameter int MS_PER_H = chg_sup_pkg::MS_PER_H,
    parameter int INT_CYC = chg_sup_pkg::INT_PULSE_CYC
) (
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // register bus
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // analog status, asynchronous
    input wire logic VBUS_OK_I,
    input wire logic NOT_SLEEP_I,
    input wire logic SRC_NOT_POOR_I,
    input wire logic TYPE_DONE_I,
    input wire logic [2:0] SRC_TYPE_I,
    input wire logic BOOST_REQ_I,
    input wire logic TS_COLD_I,
    input wire logic TS_HOT_I,
    input wire logic ABOVE_BATLOW_I,
    input wire logic IN_ILIM_I,
    input wire logic IN_VLIM_I,
    input wire logic COOL_I,
    input wire logic THERM_REG_I,
    input wire logic AT_SYSMIN_I,
    input wire logic OVP_I,
    input wire logic TSHUT_I,
    input wire logic CHG_FAULT_SUSP_I,
    input wire logic RESTART_I,
    input wire logic CHARGE_EN_PIN_N_I,
    input wire logic WAKE_RESET_PIN_N_I,
    // control outputs
    output logic CHARGE_ON_O,
    output logic BOOST_ON_O,
    output logic BATTERY_SWITCH_ON_O,
    output logic POWER_GOOD_PIN_N_O,
    output logic HOST_INTERRUPT_N_O
);
    localparam int NS = 15;
    localparam logic [NS-1:0] SYNC_IDLE = NS'(1); // wake pin idles high: no false press after reset
    localparam int TMR_W_L = chg_sup_pkg::TMR_W;
    localparam logic [TMR_W_L-1:0] ZERO_T = '0;
    localparam int PS_W = $clog2(TICK_CYC + 1);
    localparam int IC_W = $clog2(INT_CYC + 1);

    // two-flop synchronisers for every asynchronous input
    logic [NS-1:0] async_in, meta_q, sync_q;
    assign async_in = {VBUS_OK_I, NOT_SLEEP_I, SRC_NOT_POOR_I, TYPE_DONE_I, TS_COLD_I, TS_HOT_I,
                       ABOVE_BATLOW_I, IN_ILIM_I, IN_VLIM_I, COOL_I, THERM_REG_I, AT_SYSMIN_I,
                       CHG_FAULT_SUSP_I, RESTART_I, WAKE_RESET_PIN_N_I};
    logic [2:0] src_meta_q, src_q;
    logic [2:0] chg_pin_q;
    logic ovp_meta_q, ovp_q, tsh_meta_q, tsh_q, boost_meta_q, boost_q;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            meta_q <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
            src_meta_q <= '0;
            src_q <= '0;
            chg_pin_q <= '1;
            {ovp_meta_q, ovp_q, tsh_meta_q, tsh_q, boost_meta_q, boost_q} <= '0;
        end else if (CE_I) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            src_meta_q <= SRC_TYPE_I;
            src_q <= src_meta_q;
            chg_pin_q <= {chg_pin_q[1:0], CHARGE_EN_PIN_N_I};
            {ovp_meta_q, ovp_q} <= {OVP_I, ovp_meta_q};
            {tsh_meta_q, tsh_q} <= {TSHUT_I, tsh_meta_q};
            {boost_meta_q, boost_q} <= {BOOST_REQ_I, boost_meta_q};
        end
    end
    logic vbus_ok, not_sleep, not_poor, type_done, ts_cold, ts_hot, above_low;
    logic ilim, vlim, cool, threg, at_sysmin, fault_susp, restart, wake_n;
    assign {vbus_ok, not_sleep, not_poor, type_done, ts_cold, ts_hot, above_low, ilim, vlim, cool,
            threg, at_sysmin, fault_susp, restart, wake_n} = sync_q;
    logic chg_pin_n, chg_pin_toggle;
    assign chg_pin_n = chg_pin_q[1];
    assign chg_pin_toggle = chg_pin_q[2] != chg_pin_q[1];

    // register file and bus slave: one wait state for every access
    logic [31:0] ctrl_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic cfg_toggle;
    logic sw_exit;
    logic input_present;
    assign input_present = vbus_ok & not_sleep;
    logic req;
    assign req = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    logic wr_ctrl;
    assign wr_ctrl = AVS_WRITE_I & ack_q && AVS_ADDRESS_I == chg_sup_pkg::ADDR_CTRL;
    logic [31:0] wdata;
    assign wdata = AVS_WRITEDATA_I & chg_sup_pkg::CTRL_MASK;
    assign cfg_toggle = wr_ctrl && (wdata[chg_sup_pkg::C_CHG_CFG] != ctrl_q[chg_sup_pkg::C_CHG_CFG]);
    logic reg_reset;
    assign reg_reset = wr_ctrl && wdata[chg_sup_pkg::C_REG_RST];
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ctrl_q <= chg_sup_pkg::CTRL_RST;
            ack_q <= 1'b0;
        end else if (CE_I) begin
            ack_q <= req;
            if (reg_reset) begin
                ctrl_q <= chg_sup_pkg::CTRL_RST;
            end else if (wr_ctrl) begin
                ctrl_q <= wdata;
            end else if (sw_exit) begin
                ctrl_q[chg_sup_pkg::C_SW_DIS] <= 1'b0;
            end
        end
    end
    logic tmr_en, long_sel, slow_en, sw_dis, sw_dly, lp_en;
    assign tmr_en = ctrl_q[chg_sup_pkg::C_TMR_EN];
    assign long_sel = ctrl_q[chg_sup_pkg::C_LONG_SEL];
    assign slow_en = ctrl_q[chg_sup_pkg::C_SLOW_EN];
    assign sw_dis = ctrl_q[chg_sup_pkg::C_SW_DIS];
    assign sw_dly = ctrl_q[chg_sup_pkg::C_SW_DLY];
    assign lp_en = ctrl_q[chg_sup_pkg::C_LP_EN];

    // 1 ms timebase, prescaled again to half rate when slowed
    logic [PS_W-1:0] ps_q;
    logic tick;
    assign tick = ps_q == PS_W'(TICK_CYC - 1);
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ps_q <= '0;
        end else if (CE_I) begin
            ps_q <= tick ? '0 : ps_q + 1'b1;
        end
    end
    logic half_q;
    logic slow;
    assign slow = slow_en & (ilim | vlim | cool | threg);
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            half_q <= 1'b0;
        end else if (CE_I && tick) begin
            half_q <= ~half_q;
        end
    end
    logic tmr_tick;
    assign tmr_tick = tick & (~slow | half_q);

    // safety timer
    logic [TMR_W_L-1:0] tmr_q;
    logic [1:0] cf_q;
    logic timer_exp_q;
    logic tmr_clear;
    assign tmr_clear = restart | chg_pin_toggle | cfg_toggle | reg_reset;
    logic [TMR_W_L-1:0] limit;
    always_comb begin
        if (!above_low) begin
            limit = TMR_W_L'(chg_sup_pkg::SAFE_SHORT_H * MS_PER_H);
        end else if (long_sel) begin
            limit = TMR_W_L'(chg_sup_pkg::SAFE_LONG_H * MS_PER_H);
        end else begin
            limit = TMR_W_L'(chg_sup_pkg::SAFE_MID_H * MS_PER_H);
        end
    end
    logic charging;
    assign charging = ctrl_q[chg_sup_pkg::C_CHG_CFG] & ~chg_pin_n & ~timer_exp_q & ~ovp_q & ~tsh_q;
    logic tmr_hit;
    assign tmr_hit = tmr_en && charging && !fault_susp && tmr_q >= limit;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            tmr_q <= ZERO_T;
            timer_exp_q <= 1'b0;
        end else if (CE_I) begin
            if (tmr_clear || !tmr_en) begin
                tmr_q <= ZERO_T;
                timer_exp_q <= 1'b0;
            end else if (tmr_hit) begin
                timer_exp_q <= 1'b1;
            end else if (charging && !fault_susp && tmr_tick) begin
                tmr_q <= tmr_q + 1'b1;
            end
        end
    end

    // charge fault field: live conditions take priority over timer expiry
    logic [1:0] cf_d;
    always_comb begin
        if (ovp_q) begin
            cf_d = chg_sup_pkg::CF_OVP;
        end else if (tsh_q) begin
            cf_d = chg_sup_pkg::CF_TSHUT;
        end else if (timer_exp_q) begin
            cf_d = chg_sup_pkg::CF_TIMER;
        end else begin
            cf_d = chg_sup_pkg::CF_NONE;
        end
    end

    // boost thermistor window
    logic [2:0] ntc_d;
    assign ntc_d = !boost_q ? chg_sup_pkg::NTC_NORMAL : ts_cold ? chg_sup_pkg::NTC_COLD :
                   ts_hot ? chg_sup_pkg::NTC_HOT : chg_sup_pkg::NTC_NORMAL;
    logic [2:0] ntc_q, src_field_q;
    logic pg_q, flags_sys_q, flags_il_q, flags_vl_q;
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ntc_q <= chg_sup_pkg::NTC_NORMAL;
            src_field_q <= chg_sup_pkg::SRC_NONE;
            cf_q <= chg_sup_pkg::CF_NONE;
            pg_q <= 1'b0;
            {flags_sys_q, flags_il_q, flags_vl_q} <= '0;
        end else if (CE_I) begin
            ntc_q <= ntc_d;
            src_field_q <= (ntc_d != chg_sup_pkg::NTC_NORMAL) ? chg_sup_pkg::SRC_NONE : src_q;
            cf_q <= cf_d;
            pg_q <= vbus_ok & not_sleep & not_poor & type_done;
            flags_sys_q <= at_sysmin;
            flags_il_q <= ilim;
            flags_vl_q <= vlim;
        end
    end

    // interrupt pulse on each new event that arrives while no pulse is running
    logic [IC_W-1:0] ic_q;
    logic ev;
    logic pg_d1_q, inp_d1_q;
    logic [1:0] cf_d1_q;
    assign ev = (pg_q != pg_d1_q) | (cf_q != cf_d1_q && cf_q != chg_sup_pkg::CF_NONE);
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ic_q <= '0;
            {pg_d1_q, inp_d1_q, cf_d1_q} <= '0;
            HOST_INTERRUPT_N_O <= 1'b1;
        end else if (CE_I) begin
            {pg_d1_q, inp_d1_q, cf_d1_q} <= {pg_q, input_present, cf_q};
            if (ev && ic_q == '0) begin
                ic_q <= IC_W'(INT_CYC - 1);
                HOST_INTERRUPT_N_O <= 1'b0;
            end else if (ic_q != '0) begin
                ic_q <= ic_q - 1'b1;
            end else begin
                HOST_INTERRUPT_N_O <= 1'b1;
            end
        end
    end

    // wake pin low-time measurement
    logic [14:0] low_ms;
    chg_press_timer #(.CNT_W(15)) u_press (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .tick_i(tick),
        .pin_low_i(~wake_n),
        .low_ms_o(low_ms)
    );
    logic deglitched, long_press;
    assign deglitched = low_ms == 15'(chg_sup_pkg::DEGLITCH_MS);
    assign long_press = low_ms == 15'(chg_sup_pkg::LONG_PRESS_MS);

    // battery switch state machine
    chg_sup_pkg::sw_state_t sw_q;
    logic [13:0] sw_cnt_q;
    assign sw_exit = (sw_q == chg_sup_pkg::SW_OFF) && (deglitched || (input_present && !inp_d1_q));
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            sw_q <= chg_sup_pkg::SW_ON;
            sw_cnt_q <= '0;
        end else if (CE_I) begin
            case (sw_q)
                chg_sup_pkg::SW_ON: begin
                    sw_cnt_q <= '0;
                    if (sw_dis && !sw_dly) begin
                        sw_q <= chg_sup_pkg::SW_OFF;
                    end else if (sw_dis) begin
                        sw_q <= chg_sup_pkg::SW_WAIT;
                    end else if (long_press && lp_en && !vbus_ok) begin
                        sw_q <= chg_sup_pkg::SW_RST;
                    end
                end
                chg_sup_pkg::SW_WAIT: begin
                    if (!sw_dis) begin
                        sw_q <= chg_sup_pkg::SW_ON;
                    end else if (sw_cnt_q == 14'(chg_sup_pkg::SHIP_DLY_MS)) begin
                        sw_q <= chg_sup_pkg::SW_OFF;
                    end else if (tick) begin
                        sw_cnt_q <= sw_cnt_q + 1'b1;
                    end
                end
                chg_sup_pkg::SW_OFF: begin
                    sw_cnt_q <= '0;
                    if (!sw_dis || deglitched) begin
                        sw_q <= chg_sup_pkg::SW_ON;
                    end
                end
                chg_sup_pkg::SW_RST: begin
                    if (sw_cnt_q == 14'(chg_sup_pkg::SW_OFF_MS)) begin
                        sw_q <= chg_sup_pkg::SW_ON;
                        sw_cnt_q <= '0;
                    end else if (tick) begin
                        sw_cnt_q <= sw_cnt_q + 1'b1;
                    end
                end
                default: sw_q <= chg_sup_pkg::SW_ON;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            CHARGE_ON_O <= 1'b0;
            BOOST_ON_O <= 1'b0;
            BATTERY_SWITCH_ON_O <= 1'b1;
            POWER_GOOD_PIN_N_O <= 1'b1;
            AVS_READDATA_O <= '0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else if (CE_I) begin
            CHARGE_ON_O <= charging & ~fault_susp;
            BOOST_ON_O <= boost_q & (ntc_d == chg_sup_pkg::NTC_NORMAL);
            BATTERY_SWITCH_ON_O <= (sw_q == chg_sup_pkg::SW_ON) || (sw_q == chg_sup_pkg::SW_WAIT);
            POWER_GOOD_PIN_N_O <= ~pg_q;
            AVS_WAITREQUEST_O <= ~req;
            if (AVS_ADDRESS_I == chg_sup_pkg::ADDR_CTRL) begin
                AVS_READDATA_O <= ctrl_q;
            end else if (AVS_ADDRESS_I == chg_sup_pkg::ADDR_STAT) begin
                AVS_READDATA_O <= {16'h0000, src_field_q, ntc_q, cf_q, pg_q,
                                   flags_sys_q, flags_il_q, flags_vl_q, sw_q};
            end else if (AVS_ADDRESS_I == chg_sup_pkg::ADDR_TMR) begin
                AVS_READDATA_O <= 32'(tmr_q);
            end else begin
                AVS_READDATA_O <= '0;
            end
        end
    end

    // checks
    property p_int_width;
        @(posedge MCLK_I) disable iff (RST_I || !CE_I)
        $fell(HOST_INTERRUPT_N_O) |=> !HOST_INTERRUPT_N_O [*8];
    endproperty
    a_int_width: assert property (p_int_width) else $error("interrupt pulse too short");
    property p_timer_fault;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && timer_exp_q && !ovp_q && !tsh_q) |-> ##1 (cf_q == chg_sup_pkg::CF_TIMER);
    endproperty
    a_timer_fault: assert property (p_timer_fault) else $error("timer fault code wrong");
    property p_tmr_off;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && !tmr_en) |=> tmr_q == ZERO_T;
    endproperty
    a_tmr_off: assert property (p_tmr_off) else $error("timer counts while disabled");
    property p_hold;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && fault_susp && !tmr_clear && tmr_en) |=> $stable(tmr_q);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved during fault");
    property p_clear;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && tmr_clear) |=> tmr_q == ZERO_T;
    endproperty
    a_clear: assert property (p_clear) else $error("timer not zeroed");
    property p_ship_now;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && sw_q == chg_sup_pkg::SW_ON && sw_dis && !sw_dly) |=> sw_q == chg_sup_pkg::SW_OFF;
    endproperty
    a_ship_now: assert property (p_ship_now) else $error("switch not opened at once");
    property p_pg;
        @(posedge MCLK_I) disable iff (RST_I)
        CE_I ##1 CE_I |-> POWER_GOOD_PIN_N_O == !$past(pg_q);
    endproperty
    a_pg: assert property (p_pg) else $error("power good pin mismatch");
    property p_boost_ntc;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && ntc_q != chg_sup_pkg::NTC_NORMAL) |-> src_field_q == chg_sup_pkg::SRC_NONE;
    endproperty
    a_boost_ntc: assert property (p_boost_ntc) else $error("source field not cleared");
    property p_lp_off;
        @(posedge MCLK_I) disable iff (RST_I)
        (CE_I && sw_q == chg_sup_pkg::SW_ON && !lp_en && !sw_dis) |=> sw_q != chg_sup_pkg::SW_RST;
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("long press acted while disabled");
    c_int: cover property (@(posedge MCLK_I) $fell(HOST_INTERRUPT_N_O));
    c_rst: cover property (@(posedge MCLK_I) sw_q == chg_sup_pkg::SW_RST);
    c_wait: cover property (@(posedge MCLK_I) sw_q == chg_sup_pkg::SW_WAIT);
endmodule

/* sim/chg_button.sv */
/*
 * push button on the wake pin: the line idles high through its pull-up,
 * and a press holds it low.
 * assumes the caller steps it from the bench clock.
 */
module chg_button (
    input wire logic clk_i,
    output logic pin_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pin_n_o = 1'b1;
    // hold low whole cycles, then back to the pull-up level, never left floating
    task automatic press(input int n);
        @(posedge clk_i);
        pin_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_n_o <= 1'b1;
    endtask
endmodule

/* sim/charger_timer_batfet_control_test.sv */
/*
 * self-checking bench for the charger supervisor: registers, power good,
 * status flags, boost suspend, safety timer, ship mode and wake pin.
 * assumes 1 ms per cycle and 100 ms per hour to keep long counts short.
 */
module charger_timer_batfet_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int IC = 16;
    localparam logic [31:0] CR = chg_sup_pkg::CTRL_RST;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq, chg_n = 1'b1, ce = 1'b1, restart = 1'b0;
    logic [2:0] src = 3'h0;
    logic chg_on, boost_on, sw_on, pg_n, int_n, wake_n;
    logic [3:0] ad = 4'h0;
    logic [31:0] wd = 32'h0, rdata, r;
    logic [15:0] a = 16'h0;
    int n_errors = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    // only timebase, hour length and pulse width are shortened for the run
    chg_supervisor #(.TICK_CYC(1), .MS_PER_H(100), .INT_CYC(IC)) dut_u (.MCLK_I(clk), .RST_I(rst), .CE_I(ce),
        .AVS_ADDRESS_I(ad), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .VBUS_OK_I(a[0]), .NOT_SLEEP_I(a[1]), .SRC_NOT_POOR_I(a[2]), .TYPE_DONE_I(a[3]),
        .SRC_TYPE_I(src), .BOOST_REQ_I(a[4]), .TS_COLD_I(a[5]), .TS_HOT_I(a[6]), .ABOVE_BATLOW_I(a[7]),
        .IN_ILIM_I(a[8]), .IN_VLIM_I(a[9]), .COOL_I(a[10]), .THERM_REG_I(a[11]), .AT_SYSMIN_I(a[12]),
        .OVP_I(a[13]), .TSHUT_I(a[14]), .CHG_FAULT_SUSP_I(a[15]), .RESTART_I(restart), .CHARGE_EN_PIN_N_I(chg_n),
        .WAKE_RESET_PIN_N_I(wake_n), .CHARGE_ON_O(chg_on), .BOOST_ON_O(boost_on), .BATTERY_SWITCH_ON_O(sw_on),
        .POWER_GOOD_PIN_N_O(pg_n), .HOST_INTERRUPT_N_O(int_n));
    chg_button btn_u (.clk_i(clk), .pin_n_o(wake_n));
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        ad <= adr;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) n_errors++;
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic t_pg;
        int k;
        @(posedge clk);
        a <= 16'h000f;
        k = 0;
        while (int_n !== 1'b0 && k < 40) begin
            @(posedge clk);
            k++;
        end
        k = 0;
        while (int_n === 1'b0 && k < 40) begin
            @(posedge clk);
            k++;
        end
        chk(k, IC);
        chk(pg_n, 1'b0);
        bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
        chk(r[7], 1'b1);
        // each of the four input-good conditions alone must drop power good
        for (int i = 0; i < 4; i++) begin
            a[i] <= 1'b0;
            wt(8);
            chk(pg_n, 1'b1);
            a[i] <= 1'b1;
            wt(8);
            chk(pg_n, 1'b0);
        end
        $display("power good test done");
    endtask
    task automatic t_flags;
        @(posedge clk);
        a[12:8] <= 5'b10011;
        wt(8);
        bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
        chk(r[6:4], 3'b111);
        a[12:8] <= 5'b0;
        wt(8);
        bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
        chk(r[6:4], 3'b000);
        $display("flag test done");
    endtask
    // zero the timer by a pin toggle, run 100 ms, read the millisecond count
    task automatic rate(input logic [31:0] c, input logic s, input int lo, input int hi);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, c);
        a[8] <= s;
        chg_n <= 1'b1;
        wt(8);
        chg_n <= 1'b0;
        wt(100);
        bus(1'b0, chg_sup_pkg::ADDR_TMR, 32'h0);
        chk({31'h0, r >= lo && r <= hi}, 32'h1);
    endtask
    task automatic t_timer;
        rate(CR & ~32'h1, 1'b1, 0, 0);
        rate(CR, 1'b1, 45, 56);
        rate(CR & ~32'h4, 1'b1, 96, 106);
        rate(CR, 1'b0, 96, 106);
        wt(75);
        chk(chg_on, 1'b1);
        wt(30);
        chk(chg_on, 1'b0);
        bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
        chk(r[9:8], chg_sup_pkg::CF_TIMER);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, 32'h80);
        bus(1'b0, chg_sup_pkg::ADDR_CTRL, 32'h0);
        chk(r, CR);
        $display("timer test done");
    endtask
    // restart zeroes the timer; a fault and a low clock enable hold it
    task automatic t_hold;
        logic [31:0] v;
        @(posedge clk);
        restart <= 1'b1;
        wt(4);
        restart <= 1'b0;
        bus(1'b0, chg_sup_pkg::ADDR_TMR, 32'h0);
        chk(r, 32'h0);
        a[15] <= 1'b1;
        wt(4);
        bus(1'b0, chg_sup_pkg::ADDR_TMR, 32'h0);
        v = r;
        wt(30);
        bus(1'b0, chg_sup_pkg::ADDR_TMR, 32'h0);
        chk(r, v);
        a[15] <= 1'b0;
        ce <= 1'b0;
        wt(30);
        ce <= 1'b1;
        wt(10);
        bus(1'b0, chg_sup_pkg::ADDR_TMR, 32'h0);
        chk({31'h0, r >= v + 8 && r <= v + 16}, 32'h1);
        $display("hold test done");
    endtask
    task automatic t_boost;
        @(posedge clk);
        a <= 16'h0010;
        src <= 3'h2;
        wt(8);
        chk(boost_on, 1'b1);
        for (int j = 5; j < 7; j++) begin
            a[j] <= 1'b1;
            wt(8);
            chk(boost_on, 1'b0);
            bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
            chk(r[15:10], {chg_sup_pkg::SRC_NONE, j == 5 ? chg_sup_pkg::NTC_COLD : chg_sup_pkg::NTC_HOT});
            a[j] <= 1'b0;
            wt(8);
            chk(boost_on, 1'b1);
            bus(1'b0, chg_sup_pkg::ADDR_STAT, 32'h0);
            chk(r[15:10], {src, chg_sup_pkg::NTC_NORMAL});
        end
        $display("boost test done");
    endtask
    task automatic t_ship;
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR | 32'h10);
        wt(6);
        chk(sw_on, 1'b0);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR);
        wt(6);
        chk(sw_on, 1'b1);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR | 32'h30);
        wt(7990);
        chk(sw_on, 1'b1);
        wt(20);
        chk(sw_on, 1'b0);
        btn_u.press(500);
        wt(8);
        chk(sw_on, 1'b0);
        btn_u.press(1010);
        wt(8);
        chk(sw_on, 1'b1);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR | 32'h10);
        a <= 16'h0003;
        wt(8);
        chk(sw_on, 1'b1);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR);
        a <= 16'h0;
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR & ~32'h40);
        btn_u.press(16010);
        wt(4);
        chk(sw_on, 1'b1);
        bus(1'b1, chg_sup_pkg::ADDR_CTRL, CR);
        btn_u.press(16010);
        wt(4);
        chk(sw_on, 1'b0);
        wt(260);
        chk(sw_on, 1'b1);
        $display("switch test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        wt(10);
        rst <= 1'b0;
        bus(1'b0, chg_sup_pkg::ADDR_CTRL, 32'h0);
        chk(r, CR);
        bus(1'b0, 4'hc, 32'h0);
        chk(r, 32'h0);
        t_pg();
        t_flags();
        t_timer();
        t_hold();
        t_boost();
        t_ship();
        print_verdict();
    end
    // watchdog sized well above the roughly 45k cycles the tests need
    initial begin
        wt(100000);
        n_errors++;
        print_verdict();
    end
endmodule
